// ===== core/cmr_pkg.sv
`default_nettype none
package cmr_pkg;

   // Register byte addresses on the APB port.
   localparam logic [7:0] ADDR_CTL0 = 8'h00;
   localparam logic [7:0] ADDR_CTL1 = 8'h04;
   localparam logic [7:0] ADDR_RX_FLAG = 8'h08;
   localparam logic [7:0] ADDR_RX_IEN = 8'h0C;
   localparam logic [7:0] ADDR_TX_FLAG = 8'h10;
   localparam logic [7:0] ADDR_TX_IEN = 8'h14;
   localparam logic [7:0] ADDR_TX_ABRQ = 8'h18;
   localparam logic [7:0] ADDR_TX_ABAK = 8'h1C;
   localparam logic [7:0] ADDR_TX_BSEL = 8'h20;
   localparam logic [7:0] ADDR_CFG_FIRST = 8'h24;
   localparam logic [7:0] ADDR_CFG_LAST = 8'h6C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h70;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h74;

   // Configuration bytes: two bit-timing, acceptance control, 8 ids, 8 masks.
   localparam int NUM_CFG = 19;
   localparam int CFG_BT0 = 0;
   localparam int CFG_BT1 = 1;

   // Field positions.
   localparam int CTL0_INIT_REQ = 0;
   localparam int CTL0_SLEEP_REQ = 1;
   localparam int CTL0_WAKE_EN = 2;
   localparam int CTL1_INIT_ACK = 0;
   localparam int CTL1_SLEEP_ACK = 1;
   localparam int CTL1_STOP_WAIT = 2;
   localparam int RXF_WAKE = 0;
   localparam int STAT_POS = 4;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] TX_FLAG_RST = 8'hFF;

   // Resynchronisation counts: recessive bits per run, and runs needed in bus-off.
   localparam int RECESSIVE_RUN = 11;
   localparam int BUSOFF_SEQS = 128;
   localparam logic TX_RECESSIVE = 1'b1;

   // Interrupt event bit positions.
   localparam int EV_SLEEP = 0;
   localparam int EV_INIT = 1;
   localparam int EV_WAKE = 2;
   localparam int EV_SYNC = 3;
   localparam int NUM_EV = 4;

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_INIT, ST_SYNC} cmr_mode_t;

endpackage
`default_nettype wire

// ===== core/cmr_top.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: Control register bit 1 requests sleep, bit 0 requests initialization.
// R2: Sleep is entered only while nothing is received and all buffers empty.
// R3: Sleep acknowledge reads 1 once sleep has really been entered.
// R4: A write setting sleep request is refused while the wake-up flag is set.
// R5: Sleep lasts until cleared; with wake-up enabled bus activity clears it.
// R6: Clearing sleep request is ignored until request and acknowledge are 1.
// R7: Initialization request aborts traffic and drops bus synchronization.
// R8: Initialization acknowledge reads 1 once initialization is entered.
// R9: Entering initialization resets the listed flag, enable and buffer regs.
// R10: Timing, acceptance and control-1 writes only land in initialization.
// R11: Error counters keep their values across initialization.
// R12: On exit resync after 11 recessive bits, or 128 such runs in bus-off.
// R13: Clearing init request is ignored until request and acknowledge are 1.
// R14: Software writes other flag and enable bits only after init is left.
// R15: Transmit pin goes recessive at once on an initialization request.
// R16: Transmit pin goes recessive on stop, and on wait with stop-in-wait.
// R17: Software should enter sleep before requesting initialization.
// R18: Software enables wake-up and its interrupt before stop or wait.
// R19: Each acknowledge returns to 0 once its mode has been left.
module cmr_top
   import cmr_pkg::*;
#(
   parameter int unsigned NUM_TXBUF = 3,
   parameter int unsigned RUN_BITS = RECESSIVE_RUN,
   parameter int unsigned BUSOFF_RUNS = BUSOFF_SEQS
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic BUS_RX_I,
   output logic BUS_TX_O,
   input wire logic ENGINE_TX_I,
   input wire logic RX_BUSY_I,
   input wire logic BIT_TICK_I,
   input wire logic BUS_OFF_I,
   input wire logic [NUM_TXBUF-1:0] TX_SENT_I,
   input wire logic [1:0] TX_STATUS_I,
   input wire logic [1:0] RX_STATUS_I,
   input wire logic STOP_I,
   input wire logic WAIT_I,
   output logic ABORT_O,
   output logic ENGINE_RUN_O,
   output logic [15:0] BIT_TIMING_O,
   output logic IRQ_O
);

   localparam int TXW = NUM_TXBUF;

   logic init_req_ff, sleep_req_ff, wake_en_ff, wake_flag_ff;
   logic [4:0] ctl0_misc_ff;
   logic [5:0] ctl1_cfg_ff;
   logic [7:0] rx_ien_ff;
   logic [TXW-1:0] tx_flag_ff, tx_ien_ff, tx_abrq_ff, tx_abak_ff, tx_bsel_ff;
   logic [7:0] cfg_ff [NUM_CFG];
   logic [NUM_EV-1:0] irq_stat_ff, irq_mask_ff;
   cmr_mode_t state_ff, nxt_state;
   logic [3:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] seq_cnt_ff, nxt_seq_cnt;
   logic sync_done;
   logic rx_meta_ff, rx_sync_ff;
   logic bus_tx_ff, abort_ff, run_ff, irq_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;
   logic nxt_init_req, nxt_sleep_req;

   // APB decode. A request is answered one cycle after its setup cycle.
   wire setup_ph = PSEL_I & ~PENABLE_I;
   wire done_ph = PSEL_I & PENABLE_I & pready_ff;
   wire wr_done = done_ph & PWRITE_I;
   wire rd_done = done_ph & ~PWRITE_I;
   wire [7:0] wd = PWDATA_I[7:0];
   wire aligned = (PADDR_I[1:0] == 2'b00);
   wire [7:0] cfg_off = PADDR_I - ADDR_CFG_FIRST;
   wire [4:0] cfg_idx = cfg_off[6:2];
   wire cfg_hit = aligned & (PADDR_I >= ADDR_CFG_FIRST)
      & (PADDR_I <= ADDR_CFG_LAST);
   wire wr_ctl0 = wr_done & (PADDR_I == ADDR_CTL0);
   wire wr_ctl1 = wr_done & (PADDR_I == ADDR_CTL1);
   wire wr_rxf = wr_done & (PADDR_I == ADDR_RX_FLAG);
   wire wr_rxien = wr_done & (PADDR_I == ADDR_RX_IEN);
   wire wr_txf = wr_done & (PADDR_I == ADDR_TX_FLAG);
   wire wr_txien = wr_done & (PADDR_I == ADDR_TX_IEN);
   wire wr_abrq = wr_done & (PADDR_I == ADDR_TX_ABRQ);
   wire wr_bsel = wr_done & (PADDR_I == ADDR_TX_BSEL);
   wire wr_mask = wr_done & (PADDR_I == ADDR_IRQ_MASK);
   wire rd_stat = rd_done & (PADDR_I == ADDR_IRQ_STAT);

   // Handshake state seen by software.
   wire sleep_ack = (state_ff == ST_SLEEP); // R3 R19
   wire init_ack = (state_ff == ST_INIT); // R8 R19
   wire cfg_unlock = init_req_ff & init_ack; // R10
   wire stop_in_wait = ctl1_cfg_ff[CTL1_STOP_WAIT-2];
   wire bus_idle = ~RX_BUSY_I & (&tx_flag_ff); // R2
   wire wake_evt = sleep_ack & wake_en_ff & ~rx_sync_ff; // R5
   wire init_entry = (state_ff != ST_INIT) & (nxt_state == ST_INIT);
   wire sleep_entry = (state_ff != ST_SLEEP) & (nxt_state == ST_SLEEP);

   // Read view of every register; status fields come straight from inputs.
   wire [7:0] ctl0_rd = {ctl0_misc_ff, wake_en_ff, sleep_req_ff,
      init_req_ff};
   wire [7:0] ctl1_rd = {ctl1_cfg_ff, sleep_ack, init_ack};
   wire [7:0] rxf_rd = 8'(wake_flag_ff)
      | 8'({RX_STATUS_I, 4'h0});
   wire [7:0] txf_rd = 8'(tx_flag_ff) | 8'({TX_STATUS_I, 4'h0});
   wire addr_ok = aligned & (cfg_hit | (PADDR_I <= ADDR_TX_BSEL)
      | (PADDR_I == ADDR_IRQ_STAT) | (PADDR_I == ADDR_IRQ_MASK));
   wire [7:0] rd_byte =
      (PADDR_I == ADDR_CTL0) ? ctl0_rd :
      (PADDR_I == ADDR_CTL1) ? ctl1_rd :
      (PADDR_I == ADDR_RX_FLAG) ? rxf_rd :
      (PADDR_I == ADDR_RX_IEN) ? rx_ien_ff :
      (PADDR_I == ADDR_TX_FLAG) ? txf_rd :
      (PADDR_I == ADDR_TX_IEN) ? 8'(tx_ien_ff) :
      (PADDR_I == ADDR_TX_ABRQ) ? 8'(tx_abrq_ff) :
      (PADDR_I == ADDR_TX_ABAK) ? 8'(tx_abak_ff) :
      (PADDR_I == ADDR_TX_BSEL) ? 8'(tx_bsel_ff) :
      (PADDR_I == ADDR_IRQ_STAT) ? 8'(irq_stat_ff) :
      (PADDR_I == ADDR_IRQ_MASK) ? 8'(irq_mask_ff) :
      cfg_hit ? cfg_ff[cfg_idx] : RST_BYTE;
   wire [31:0] rd_word = addr_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;

   // Bus slave: data is latched in the setup cycle so the answer is a flop.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
         if (setup_ph) begin
            prdata_ff <= rd_word;
            pslverr_ff <= ~addr_ok;
         end
      end
   end

   // Request bits. Writes that would break the handshake are dropped.
   always_comb begin
      nxt_init_req = init_req_ff;
      nxt_sleep_req = sleep_req_ff;
      if (wr_ctl0) begin
         if (wd[CTL0_INIT_REQ]) begin // R1
            nxt_init_req = 1'b1;
         end else if (cfg_unlock) begin // R13
            nxt_init_req = 1'b0;
         end
         if (wd[CTL0_SLEEP_REQ]) begin // R1
            nxt_sleep_req = sleep_req_ff | ~wake_flag_ff; // R4
         end else if (sleep_req_ff & sleep_ack) begin // R6
            nxt_sleep_req = 1'b0;
         end
      end
      if (wake_evt) begin // R5
         nxt_sleep_req = 1'b0;
      end
   end

   // Control register 0; only its spare bits fall back on init entry.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         init_req_ff <= 1'b0;
         sleep_req_ff <= 1'b0;
         wake_en_ff <= 1'b0;
         ctl0_misc_ff <= 5'h0;
      end else begin
         init_req_ff <= nxt_init_req;
         sleep_req_ff <= nxt_sleep_req;
         if (wr_ctl0) begin
            wake_en_ff <= wd[CTL0_WAKE_EN];
         end
         if (init_entry) begin
            ctl0_misc_ff <= 5'h0; // R9
         end else if (wr_ctl0) begin
            ctl0_misc_ff <= wd[7:3];
         end
      end
   end

   // Locked configuration: control 1 spare bits and all timing and acceptance bytes.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctl1_cfg_ff <= 6'h00;
      end else if (wr_ctl1 & cfg_unlock) begin // R10
         ctl1_cfg_ff <= wd[7:2];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CFG; g++) begin : g_cfg
         always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
            if (RST_I) begin
               cfg_ff[g] <= RST_BYTE;
            end else if (wr_done & cfg_hit & cfg_unlock
               & (cfg_idx == 5'(g))) begin // R10
               cfg_ff[g] <= wd;
            end
         end
      end
   endgenerate

   // Receiver flag and enable. A new wake-up beats a clear in the same cycle.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wake_flag_ff <= 1'b0;
         rx_ien_ff <= RST_BYTE;
      end else if (init_entry) begin
         wake_flag_ff <= 1'b0; // R9
         rx_ien_ff <= RST_BYTE; // R9
      end else begin
         wake_flag_ff <= wake_evt
            | (wake_flag_ff & ~(wr_rxf & wd[RXF_WAKE]));
         if (wr_rxien) begin
            rx_ien_ff <= wd;
         end
      end
   end

   // Transmit buffer registers. Set by the engine wins over a software clear.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tx_flag_ff <= TX_FLAG_RST[TXW-1:0];
         tx_ien_ff <= '0;
         tx_abrq_ff <= '0;
         tx_abak_ff <= '0;
         tx_bsel_ff <= '0;
      end else if (init_entry) begin // R9
         tx_flag_ff <= TX_FLAG_RST[TXW-1:0];
         tx_ien_ff <= '0;
         tx_abrq_ff <= '0;
         tx_abak_ff <= '0;
         tx_bsel_ff <= '0;
      end else begin
         tx_flag_ff <= TX_SENT_I | (tx_flag_ff & ~(wd[TXW-1:0]
            & {TXW{wr_txf}}));
         tx_abrq_ff <= (tx_abrq_ff | (wd[TXW-1:0] & {TXW{wr_abrq}}))
            & ~TX_SENT_I;
         tx_abak_ff <= (tx_abrq_ff & TX_SENT_I)
            | (tx_abak_ff & ~(wd[TXW-1:0] & {TXW{wr_txf}}));
         if (wr_txien) begin
            tx_ien_ff <= wd[TXW-1:0];
         end
         if (wr_bsel) begin
            tx_bsel_ff <= wd[TXW-1:0];
         end
      end
   end

   // Mode sequencer. Resync counts recessive bits at each sample tick and
   // restarts the count on any dominant bit.
   always_comb begin
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_seq_cnt = seq_cnt_ff;
      sync_done = 1'b0;
      case (state_ff)
         ST_RUN: begin
            if (init_req_ff) begin
               nxt_state = ST_INIT; // R7
            end else if (sleep_req_ff & bus_idle) begin
               nxt_state = ST_SLEEP; // R2
            end
         end
         ST_SLEEP: begin
            if (init_req_ff) begin
               nxt_state = ST_INIT;
            end else if (!sleep_req_ff) begin
               nxt_state = ST_RUN; // R19
            end
         end
         ST_INIT: begin
            nxt_bit_cnt = 4'h0;
            nxt_seq_cnt = 8'h00;
            if (!init_req_ff) begin
               nxt_state = ST_SYNC; // R19
            end
         end
         ST_SYNC: begin
            if (init_req_ff) begin
               nxt_state = ST_INIT;
            end else if (BIT_TICK_I) begin
               if (!rx_sync_ff) begin
                  nxt_bit_cnt = 4'h0;
               end else if (bit_cnt_ff == 4'(RUN_BITS - 1)) begin // R12
                  nxt_bit_cnt = 4'h0;
                  if (!BUS_OFF_I
                     || seq_cnt_ff == 8'(BUSOFF_RUNS - 1)) begin // R12
                     nxt_state = ST_RUN;
                     sync_done = 1'b1;
                  end else begin
                     nxt_seq_cnt = seq_cnt_ff + 8'h01;
                  end
               end else begin
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end
            end
         end
         default: begin
            nxt_state = ST_INIT;
         end
      endcase
   end

   // Receive pin synchroniser and sequencer state.
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rx_meta_ff <= TX_RECESSIVE;
         rx_sync_ff <= TX_RECESSIVE;
         state_ff <= ST_RUN;
         bit_cnt_ff <= 4'h0;
         seq_cnt_ff <= 8'h00;
      end else begin
         rx_meta_ff <= BUS_RX_I;
         rx_sync_ff <= rx_meta_ff;
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         seq_cnt_ff <= nxt_seq_cnt;
      end
   end

   // Pin and engine control. The recessive force looks at the request as it
   // is written, so the pin never waits for a frame boundary. The error
   // counters live in the engine and are never touched from here (R11).
   wire force_rec = nxt_init_req | STOP_I | (WAIT_I & stop_in_wait)
      | (nxt_state != ST_RUN); // R15 R16
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bus_tx_ff <= TX_RECESSIVE;
         abort_ff <= 1'b0;
         run_ff <= 1'b0;
      end else begin
         bus_tx_ff <= force_rec ? TX_RECESSIVE : ENGINE_TX_I; // R15 R16
         abort_ff <= init_entry; // R7
         run_ff <= (nxt_state == ST_RUN); // R7
      end
   end

   // Interrupts: sticky events, cleared by reading the status register.
   wire [NUM_EV-1:0] events;
   assign events[EV_SLEEP] = sleep_entry;
   assign events[EV_INIT] = init_entry;
   assign events[EV_WAKE] = wake_evt;
   assign events[EV_SYNC] = sync_done;
   // Only the bits that the read returned are cleared, so an event that
   // lands during the setup cycle of that read is kept for the next one.
   wire [NUM_EV-1:0] stat_read = prdata_ff[NUM_EV-1:0] & {NUM_EV{rd_stat}};
   wire [NUM_EV-1:0] nxt_irq_stat = events | (irq_stat_ff & ~stat_read);
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         if (wr_mask) begin
            irq_mask_ff <= wd[NUM_EV-1:0];
         end
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   assign PRDATA_O = prdata_ff;
   assign PREADY_O = pready_ff;
   assign PSLVERR_O = pslverr_ff;
   assign BUS_TX_O = bus_tx_ff;
   assign ABORT_O = abort_ff;
   assign ENGINE_RUN_O = run_ff;
   assign BIT_TIMING_O = {cfg_ff[CFG_BT1], cfg_ff[CFG_BT0]};
   assign IRQ_O = irq_ff;

   // Checks on the handshake; all sampled on the system clock.
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);

   AST_SLEEP_IDLE: assert property ( // R2
      (state_ff == ST_RUN) ##1 (state_ff == ST_SLEEP)
      |-> $past(bus_idle)) else $error("sleep entered on busy bus");
   AST_SLEEP_ACK: assert property ( // R3
      (state_ff == ST_RUN && sleep_req_ff && bus_idle && !init_req_ff)
      |=> (ctl1_rd[CTL1_SLEEP_ACK] == 1'b1))
      else $error("sleep ack not set");
   AST_SLEEP_REFUSE: assert property ( // R4
      (wr_ctl0 && wd[CTL0_SLEEP_REQ] && wake_flag_ff && !sleep_req_ff)
      |=> !sleep_req_ff) else $error("sleep request taken with wake flag");
   AST_WAKE_CLEAR: assert property ( // R5
      wake_evt |=> !sleep_req_ff ##1 !sleep_ack)
      else $error("wake-up did not end sleep");
   AST_SLEEP_HOLD: assert property ( // R6
      (wr_ctl0 && !wd[CTL0_SLEEP_REQ] && sleep_req_ff && !sleep_ack
      && !wake_evt) |=> sleep_req_ff)
      else $error("sleep request cleared before ack");
   AST_INIT_ABORT: assert property ( // R7
      (init_req_ff && state_ff == ST_RUN)
      |=> (ABORT_O && !ENGINE_RUN_O && init_ack))
      else $error("init did not abort the engine");
   AST_INIT_RESET: assert property ( // R9
      init_entry |=> (tx_flag_ff == TX_FLAG_RST[TXW-1:0]
      && tx_abrq_ff == '0 && rx_ien_ff == RST_BYTE && !wake_flag_ff))
      else $error("init entry left registers set");
   AST_CFG_LOCK: assert property ( // R10
      !cfg_unlock |=> $stable(BIT_TIMING_O) && $stable(ctl1_cfg_ff))
      else $error("locked register changed");
   AST_RESYNC: assert property ( // R12
      (state_ff == ST_SYNC && !init_req_ff && !BUS_OFF_I && BIT_TICK_I
      && rx_sync_ff && bit_cnt_ff == 4'(RUN_BITS - 1))
      |=> (state_ff == ST_RUN && ENGINE_RUN_O))
      else $error("resync after recessive run failed");
   AST_INIT_HOLD: assert property ( // R13
      (wr_ctl0 && !wd[CTL0_INIT_REQ] && init_req_ff && !init_ack)
      |=> init_req_ff) else $error("init request cleared before ack");
   AST_TX_INIT: assert property ( // R15
      init_req_ff |-> BUS_TX_O) else $error("pin dominant during init");
   AST_TX_STOP: assert property ( // R16
      (STOP_I || (WAIT_I && stop_in_wait)) |=> BUS_TX_O)
      else $error("pin dominant in stop or wait");
   AST_ACK_DROP: assert property ( // R19
      (init_ack && !init_req_ff) |=> !init_ack)
      else $error("init ack stayed after exit");

   COV_SLEEP: cover property (sleep_entry ##[1:50] wake_evt);
   COV_INIT_EXIT: cover property (init_ack ##[1:400] sync_done);
   COV_BUSOFF: cover property (
      state_ff == ST_SYNC && BUS_OFF_I && seq_cnt_ff == 8'h01);
   COV_IRQ: cover property ($rose(IRQ_O));

endmodule
`default_nettype wire

// ===== test/cmr_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmr_bus_model #(
   parameter int unsigned TICK_DIV = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tx_i,
   input wire logic dom_i,
   input wire logic tick_en_i,
   output logic rx_o,
   output logic tick_o
);
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic wrap;

   // The line is a wired AND, so one dominant node wins over recessive.
   assign rx_o = tx_i & ~dom_i;
   assign wrap = (cnt_ff == 4'(TICK_DIV - 1));
   assign nxt_cnt = (!tick_en_i || wrap) ? 4'h0 : cnt_ff + 4'h1;

   // Sample points only come while the far side runs, which fixes the phase.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 4'h0;
         tick_o <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_o <= wrap & tick_en_i;
      end
   end
endmodule
`default_nettype wire

// ===== test/test_can_mode_request_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_can_mode_request_control;
   import cmr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, eng_tx = 1'b1, rx_busy = 1'b0, bus_off = 1'b0;
   logic cpu_stop = 1'b0, cpu_wait = 1'b0, dom = 1'b0, tick_en = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [2:0] tx_sent = 3'h0;
   logic [1:0] tx_st = 2'h0, rx_st = 2'h0;
   logic [31:0] prdata;
   logic [15:0] bt;
   logic pready, pslverr, bus_rx, bus_tx, tick, abort, run, irq;
   int n_fail = 0, n_checks = 0, n_abort = 0;

   // The run is kept short by a two-run bus-off wait.
   cmr_top #(.NUM_TXBUF(3), .RUN_BITS(11), .BUSOFF_RUNS(2)) dut_u (
      .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .BUS_RX_I(bus_rx), .BUS_TX_O(bus_tx), .ENGINE_TX_I(eng_tx),
      .RX_BUSY_I(rx_busy), .BIT_TICK_I(tick), .BUS_OFF_I(bus_off),
      .TX_SENT_I(tx_sent), .TX_STATUS_I(tx_st), .RX_STATUS_I(rx_st),
      .STOP_I(cpu_stop), .WAIT_I(cpu_wait), .ABORT_O(abort),
      .ENGINE_RUN_O(run), .BIT_TIMING_O(bt), .IRQ_O(irq));
   cmr_bus_model #(.TICK_DIV(8)) bus_u (.clk_i(clk), .rst_i(rst),
      .tx_i(bus_tx), .dom_i(dom), .tick_en_i(tick_en), .rx_o(bus_rx),
      .tick_o(tick));

   // Free-running clock and a count of abort pulses for later comparison.
   always #5 clk = ~clk;
   always @(posedge clk) if (abort === 1'b1) n_abort <= n_abort + 1;

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
   endtask

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_fail++;
         final_report();
      end
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h00_0000, d}, q, e);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(what, {24'h00_0000, exp}, q);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Counts sample points under a bound, so a silent far side cannot hang.
   task automatic ticks(input int k);
      int n;
      n = 0;
      while (k > 0 && n < 4000) begin
         @(posedge clk);
         n++;
         if (tick === 1'b1) k--;
      end
      if (k > 0) begin
         n_fail++;
         final_report();
      end
   endtask

   task automatic t_reset();
      logic [31:0] q;
      logic e;
      rd_chk("ctl0 at reset", ADDR_CTL0, 8'h00);
      rd_chk("ctl1 at reset", ADDR_CTL1, 8'h00);
      apb(1'b0, 8'h80, 32'h0000_0000, q, e);
      chk1("unmapped error", 1'b1, e);
      chk("unmapped data", 32'h0000_0000, q);
   endtask

   task automatic t_sleep();
      rx_busy <= 1'b1;
      wr(ADDR_CTL0, 8'h02);
      cyc(4);
      rd_chk("sleep ack while busy", ADDR_CTL1, 8'h00);
      wr(ADDR_CTL0, 8'h00);
      rd_chk("early sleep clear", ADDR_CTL0, 8'h02);
      rx_busy <= 1'b0;
      cyc(4);
      rd_chk("sleep ack", ADDR_CTL1, 8'h02);
   endtask

   task automatic t_wake();
      wr(ADDR_CTL0, 8'h06);
      wr(ADDR_RX_IEN, 8'h01);
      dom <= 1'b1;
      cyc(8);
      dom <= 1'b0;
      rd_chk("wake clears request", ADDR_CTL0, 8'h04);
      rd_chk("sleep ack after wake", ADDR_CTL1, 8'h00);
      rd_chk("wake flag", ADDR_RX_FLAG, 8'h01);
      wr(ADDR_CTL0, 8'h06);
      rd_chk("sleep refused", ADDR_CTL0, 8'h04);
      wr(ADDR_RX_FLAG, 8'h01);
      rd_chk("wake flag cleared", ADDR_RX_FLAG, 8'h00);
   endtask

   task automatic t_init();
      int a0;
      tx_st <= 2'h2;
      rx_st <= 2'h1;
      wr(ADDR_TX_FLAG, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h02);
      rd_chk("irq status flush", ADDR_IRQ_STAT, 8'h05);
      wr(ADDR_TX_IEN, 8'h05);
      wr(ADDR_CFG_FIRST, 8'h5A);
      chk("timing locked", 32'h0000_0000, {16'h0000, bt});
      eng_tx <= 1'b0;
      cyc(3);
      chk1("tx passes", 1'b0, bus_tx);
      a0 = n_abort;
      wr(ADDR_CTL0, 8'h85);
      chk1("tx forced", 1'b1, bus_tx);
      cyc(2);
      chk("abort pulses", 32'h0000_0001, n_abort - a0);
      chk1("engine stopped", 1'b0, run);
      chk1("init irq", 1'b1, irq);
      rd_chk("init ack", ADDR_CTL1, 8'h01);
      rd_chk("ctl0 in init", ADDR_CTL0, 8'h05);
      rd_chk("tx ien in init", ADDR_TX_IEN, 8'h00);
      rd_chk("rx ien in init", ADDR_RX_IEN, 8'h00);
      rd_chk("tx flags in init", ADDR_TX_FLAG, 8'h27);
      rd_chk("rx flags in init", ADDR_RX_FLAG, 8'h10);
      rd_chk("irq status", ADDR_IRQ_STAT, 8'h02);
      chk1("irq cleared", 1'b0, irq);
      wr(ADDR_CFG_FIRST, 8'h5A);
      wr(ADDR_CFG_FIRST + 8'h04, 8'hC3);
      wr(ADDR_CTL1, 8'h04);
      chk("timing", 32'h0000_C35A, {16'h0000, bt});
      rd_chk("ctl1 in init", ADDR_CTL1, 8'h05);
   endtask

   // Leaves init with the far side quiet, then lets k recessive bits pass.
   task automatic resync(input int k, input logic [7:0] c1);
      tick_en <= 1'b0;
      wr(ADDR_CTL0, 8'h04);
      rd_chk("init ack left", ADDR_CTL1, c1);
      tick_en <= 1'b1;
      ticks(k - 1);
      cyc(4);
      chk1("still syncing", 1'b0, run);
      ticks(1);
      cyc(4);
      chk1("running", 1'b1, run);
      chk1("resync masked", 1'b0, irq);
   endtask

   task automatic t_stop();
      chk1("tx passes again", 1'b0, bus_tx);
      cpu_stop <= 1'b1;
      cyc(2);
      chk1("stop forces", 1'b1, bus_tx);
      cpu_stop <= 1'b0;
      cyc(2);
      chk1("stop left", 1'b0, bus_tx);
      cpu_wait <= 1'b1;
      cyc(2);
      chk1("wait forces", 1'b1, bus_tx);
      cpu_wait <= 1'b0;
      cyc(2);
   endtask

   task automatic t_busoff();
      wr(ADDR_TX_FLAG, 8'h02);
      wr(ADDR_CTL0, 8'h02);
      rd_chk("sleep ack, buffer full", ADDR_CTL1, 8'h04);
      tx_sent <= 3'h2;
      cyc(1);
      tx_sent <= 3'h0;
      cyc(2);
      rd_chk("sleep before init", ADDR_CTL1, 8'h06);
      wr(ADDR_CTL0, 8'h05);
      rd_chk("irq status in init", ADDR_IRQ_STAT, 8'h0B);
      wr(ADDR_CTL1, 8'h00);
      bus_off <= 1'b1;
      resync(22, 8'h00);
      cpu_wait <= 1'b1;
      cyc(2);
      chk1("wait without stop", 1'b0, bus_tx);
      cpu_wait <= 1'b0;
   endtask

   // Main sequence after an eight-cycle reset.
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_sleep();
      t_wake();
      t_init();
      resync(11, 8'h04);
      t_stop();
      t_busoff();
      final_report();
   end

   // A hang anywhere ends the run as a mismatch.
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule
`default_nettype wire
